/* File: rtl/ulst_trap_config.v */
// Summary of operation
// [RULE1] Enable bit 13 gates controller PCI interrupt
// [RULE2] Bit 12 shows raw controller interrupt, read-only
// [RULE3] Port 64h write sets bit 11
// [RULE4] Port 64h read sets bit 10
// [RULE5] Port 60h write sets bit 9
// [RULE6] Port 60h read sets bit 8
// [RULE7] Write one clears status, all functions
// [RULE8] Bit 7 raises SMI after pass-through ends
// [RULE9] Bit 6 shows mid-sequence; disable clears it
// [RULE10] Gate sequence writes pass without status
// [RULE11] Bit 4 turns USB interrupt into SMI
// [RULE12] Enables 3..0 gate status 11..8 onto SMI
// [RULE13] Wake enables select monitored ports
// [RULE14] Alignment holds first frame for heartbeat
// [RULE15] Halted read value set by mode bit
// [RULE16] Policy 0: bus master from accesses
// [RULE17] Policy 1: bus master while not halted
// [RULE18] Arbitration disable orders DMA before target
// [RULE19] Enables ORed, status shared across functions
// [RULE20] Bit 15 set at pass-through end
// [RULE21] Reserved bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
`include "ulst_defines.vh"

module ulst_trap_config (
    input  wire        i_clk,
    input  wire        i_reset,
    // Configuration cycle port, dword addressed
    input  wire        i_cfg_wr,
    input  wire        i_cfg_rd,
    input  wire [7:0]  i_cfg_addr,
    input  wire [3:0]  i_cfg_be,
    input  wire [31:0] i_cfg_wdata,
    output reg  [31:0] o_cfg_rdata,
    output reg         o_cfg_rvalid,
    // Keyboard controller port cycles
    input  wire        i_kbc_access,
    input  wire        i_kbc_write,
    input  wire        i_kbc_cmd_port,
    input  wire [7:0]  i_kbc_wdata,
    output reg         o_address_line_gate,
    // Sharing with sibling functions
    input  wire [4:0]  i_peer_enable,
    input  wire [4:0]  i_peer_status_clear,
    output reg  [4:0]  o_local_enable,
    output reg  [4:0]  o_status_clear,
    // Controller interrupt and SMI
    input  wire        i_usb_irq,
    output reg         o_pci_irq,
    output reg         o_system_mgmt_interrupt,
    // Wake monitoring
    input  wire [1:0]  i_port_wake_event,
    output reg         o_wake_event,
    // Frame alignment and halted reporting
    input  wire        i_run,
    input  wire        i_heartbeat,
    input  wire        i_halted_raw,
    output reg         o_frame_start_enable,
    output reg         o_controller_halted,
    // Bus master status and arbitration
    input  wire        i_mem_access_active,
    input  wire        i_dma_read_pending,
    output reg         o_busmaster_status,
    output reg         o_target_completion_hold
);

    reg [15:0] legacy;
    reg [7:0]  usb_resume_port_enable;
    reg [7:0]  core_well_policy;
    reg [7:0]  host_config_one;
    reg [1:0]  pass_state;
    reg [1:0]  next_pass_state;
    reg        run_q;
    reg        align_wait;

    // Shared status bits in order: 15, 11, 10, 9, 8
    wire [4:0] sts_now = {legacy[`ULST_B_END_STS], legacy[`ULST_F_TRAP_STS]};
    // Local enables in order: 7, 3, 2, 1, 0
    wire [4:0] en_local = {legacy[`ULST_B_END_EN], legacy[`ULST_F_TRAP_EN]};
    wire [4:0] en_eff = en_local | i_peer_enable; // RULE19
    // Pass-through enable is local only, unlike the trap enables
    wire pass_en_eff = legacy[`ULST_B_PASS_EN];
    wire trap_smi = |(sts_now & en_eff); // RULE8 RULE12
    wire usb_smi = legacy[`ULST_B_USB_STS] & legacy[`ULST_B_USB_EN]; // RULE11
    reg  next_align_wait;

    wire dw_leg = i_cfg_wr && (i_cfg_addr == `ULST_LEGACY_DW);
    wire dw_res = i_cfg_wr && (i_cfg_addr == `ULST_RESUME_DW);
    wire dw_pol = i_cfg_wr && (i_cfg_addr == `ULST_POLICY_DW);

    function [15:0] be_mask16;
        input [1:0] be;
        begin
            be_mask16 = {{8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    function [7:0] merge8;
        input [7:0] old;
        input [7:0] wd;
        input [7:0] wmask;
        input       en;
        begin
            merge8 = en ? ((old & ~wmask) | (wd & wmask)) : old;
        end
    endfunction

    wire [15:0] leg_bm = be_mask16(i_cfg_be[1:0]);
    wire [15:0] leg_w1c = dw_leg ? (i_cfg_wdata[15:0] & leg_bm & `ULST_LEG_W1C) : 16'h0000;
    wire [4:0]  clr_local = {leg_w1c[`ULST_B_END_STS], leg_w1c[`ULST_F_TRAP_STS]};
    wire [4:0]  clr_all = clr_local | i_peer_status_clear; // RULE7

    // Gate pass-through sequence: 64h<-D1, 60h<-data, 64h<-FF
    reg seq_write;
    reg seq_end;
    always @* begin
        next_pass_state = pass_state;
        seq_write = 1'b0;
        seq_end = 1'b0;
        if (!pass_en_eff) begin
            next_pass_state = `ULST_PS_IDLE; // RULE9
        end else if (i_kbc_access && i_kbc_write) begin
            case (pass_state)
                `ULST_PS_IDLE: begin
                    if (i_kbc_cmd_port && i_kbc_wdata == `ULST_GATE_CMD) begin
                        next_pass_state = `ULST_PS_DATA; // RULE10
                        seq_write = 1'b1;
                    end
                end
                `ULST_PS_DATA: begin
                    if (!i_kbc_cmd_port) begin
                        next_pass_state = `ULST_PS_END; // RULE10
                        seq_write = 1'b1;
                    end else begin
                        next_pass_state = `ULST_PS_IDLE;
                    end
                end
                `ULST_PS_END: begin
                    next_pass_state = `ULST_PS_IDLE;
                    if (i_kbc_cmd_port && i_kbc_wdata == `ULST_GATE_END) begin
                        seq_write = 1'b1; // RULE10
                        seq_end = 1'b1;
                    end
                end
                default: begin
                    next_pass_state = `ULST_PS_IDLE;
                end
            endcase
        end else if (i_kbc_access && pass_state != `ULST_PS_IDLE) begin
            // A stray read breaks the sequence and is trapped normally
            next_pass_state = `ULST_PS_IDLE;
        end
    end

    // Trap events in order: end, 64h write, 64h read, 60h write, 60h read
    wire [4:0] set_ev;
    assign set_ev[4] = seq_end; // RULE20
    assign set_ev[3] = i_kbc_access & i_kbc_write & i_kbc_cmd_port & ~seq_write; // RULE3
    assign set_ev[2] = i_kbc_access & ~i_kbc_write & i_kbc_cmd_port; // RULE4
    assign set_ev[1] = i_kbc_access & i_kbc_write & ~i_kbc_cmd_port & ~seq_write; // RULE5
    assign set_ev[0] = i_kbc_access & ~i_kbc_write & ~i_kbc_cmd_port; // RULE6

    // Set wins over a clear in the same cycle
    wire [4:0] next_sts = set_ev | (sts_now & ~clr_all);

    // Legacy trap control register
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            legacy <= `ULST_LEG_RESET; // RULE1
        end else begin
            if (dw_leg) begin
                legacy[`ULST_F_LOW_BYTE] <= merge8(legacy[`ULST_F_LOW_BYTE],
                                                   i_cfg_wdata[`ULST_F_LOW_BYTE],
                                                   `ULST_LEG_WMASK_LO, i_cfg_be[0]); // RULE21
                legacy[`ULST_B_PCI_IRQ_EN] <= i_cfg_be[1] ?
                    i_cfg_wdata[`ULST_B_PCI_IRQ_EN] : legacy[`ULST_B_PCI_IRQ_EN];
            end
            legacy[`ULST_B_IN_PROG] <= (next_pass_state != `ULST_PS_IDLE); // RULE9
            legacy[`ULST_B_USB_STS] <= i_usb_irq; // RULE2
            legacy[`ULST_B_END_STS] <= next_sts[4];
            legacy[`ULST_F_TRAP_STS] <= next_sts[3:0];
            legacy[`ULST_B_RSVD] <= 1'b0;
        end
    end

    // Sequence state and the clear pulse handed to siblings
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pass_state <= `ULST_PS_IDLE;
            o_status_clear <= 5'h00;
        end else begin
            pass_state <= next_pass_state;
            o_status_clear <= clr_local; // RULE7
        end
    end

    // Narrow registers; reserved bits masked off
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            usb_resume_port_enable <= `ULST_RESUME_RESET;
            core_well_policy <= `ULST_POLICY_RESET;
            host_config_one <= `ULST_CFG1_RESET;
        end else begin
            usb_resume_port_enable <= merge8(usb_resume_port_enable,
                                             i_cfg_wdata[`ULST_F_LOW_BYTE],
                                             `ULST_RESUME_WMASK, dw_res & i_cfg_be[0]); // RULE21
            core_well_policy <= merge8(core_well_policy,
                                       i_cfg_wdata[`ULST_F_LOW_BYTE],
                                       `ULST_POLICY_WMASK, dw_pol & i_cfg_be[0]);
            host_config_one <= merge8(host_config_one,
                                      i_cfg_wdata[`ULST_F_CFG1_LANE],
                                      `ULST_CFG1_WMASK, dw_pol & i_cfg_be[`ULST_LANE_CFG1]);
        end
    end

    // Outputs use the next wait value, so the first
    // run cycle cannot leak a frame start
    always @* begin
        next_align_wait = align_wait;
        if (!i_run || i_heartbeat) begin
            next_align_wait = 1'b0;
        end else if (!run_q && core_well_policy[`ULST_B_ALIGN_EN]) begin
            next_align_wait = 1'b1; // RULE14
        end
    end

    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            run_q <= 1'b0;
            align_wait <= 1'b0;
        end else begin
            run_q <= i_run;
            align_wait <= next_align_wait;
        end
    end

    // Read strobe echoed one cycle later with its data
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_cfg_rvalid <= 1'b0;
        end else begin
            o_cfg_rvalid <= i_cfg_rd;
        end
    end

    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_cfg_rdata <= 32'h00000000;
        end else if (i_cfg_rd) begin
            case (i_cfg_addr)
                `ULST_LEGACY_DW: o_cfg_rdata <= {16'h0000, legacy};
                `ULST_RESUME_DW: o_cfg_rdata <= {24'h000000, usb_resume_port_enable};
                `ULST_POLICY_DW: o_cfg_rdata <= {8'h00, host_config_one,
                                                 8'h00, core_well_policy};
                default:         o_cfg_rdata <= 32'h00000000; // RULE21
            endcase
        end
    end

    // Gate level follows only an accepted data byte
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_address_line_gate <= 1'b0;
        end else if (seq_write && pass_state == `ULST_PS_DATA) begin
            o_address_line_gate <= i_kbc_wdata[`ULST_B_GATE_DATA]; // RULE10
        end
    end

    // Same bit order as the peer input, so siblings can OR
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_local_enable <= 5'h00;
        end else begin
            o_local_enable <= en_local; // RULE19
        end
    end

    // Controller interrupt
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pci_irq <= 1'b0;
        end else begin
            o_pci_irq <= i_usb_irq & legacy[`ULST_B_PCI_IRQ_EN]; // RULE1
        end
    end

    // System management interrupt
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_system_mgmt_interrupt <= 1'b0;
        end else begin
            o_system_mgmt_interrupt <= trap_smi | usb_smi; // RULE8 RULE11 RULE12
        end
    end

    // Wake monitoring
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_wake_event <= 1'b0;
        end else begin
            o_wake_event <= |(i_port_wake_event & usb_resume_port_enable[`ULST_F_WAKE_EN]); // RULE13
        end
    end

    // Frame start
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_frame_start_enable <= 1'b0;
        end else begin
            o_frame_start_enable <= i_run & ~next_align_wait; // RULE14
        end
    end

    // Halted value seen by software
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_controller_halted <= 1'b1;
        end else if (next_align_wait) begin
            o_controller_halted <= ~core_well_policy[`ULST_B_HALT_MODE]; // RULE15
        end else begin
            o_controller_halted <= i_halted_raw;
        end
    end

    // Bus master status policy
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_busmaster_status <= 1'b0;
        end else if (core_well_policy[`ULST_B_STATIC_BM]) begin
            o_busmaster_status <= ~i_halted_raw; // RULE17
        end else begin
            o_busmaster_status <= i_mem_access_active; // RULE16
        end
    end

    // Arbitration hold
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_target_completion_hold <= 1'b0;
        end else begin
            o_target_completion_hold <= host_config_one[`ULST_B_ARB_DIS] & i_dma_read_pending; // RULE18
        end
    end

endmodule // ulst_trap_config
`default_nettype wire

/* File: rtl/ulst_defines.vh */
`ifndef ULST_DEFINES_VH
`define ULST_DEFINES_VH

// Configuration dword addresses
`define ULST_LEGACY_DW      8'hc0
`define ULST_RESUME_DW      8'hc4
`define ULST_POLICY_DW      8'hc8
// Byte offsets of the narrow registers
`define ULST_RESUME_OFS     8'hc4
`define ULST_POLICY_OFS     8'hc8
`define ULST_CONFIG_ONE_OFS 8'hca
`define ULST_LANE_CFG1      2'h2

// Legacy trap control fields
`define ULST_LEG_RESET      16'h2000
`define ULST_LEG_WMASK      16'h20bf
`define ULST_LEG_W1C        16'h8f00
`define ULST_LEG_WMASK_LO   8'hbf
`define ULST_B_RSVD         14
`define ULST_F_TRAP_STS     11:8
`define ULST_F_TRAP_EN      3:0
`define ULST_F_LOW_BYTE     7:0
`define ULST_F_CFG1_LANE    23:16
`define ULST_F_WAKE_EN      1:0
`define ULST_B_END_STS      15
`define ULST_B_PCI_IRQ_EN   13
`define ULST_B_USB_STS      12
`define ULST_B_CMDW_STS     11
`define ULST_B_CMDR_STS     10
`define ULST_B_DATW_STS     9
`define ULST_B_DATR_STS     8
`define ULST_B_END_EN       7
`define ULST_B_IN_PROG      6
`define ULST_B_PASS_EN      5
`define ULST_B_USB_EN       4

// Other registers
`define ULST_RESUME_RESET   8'h00
`define ULST_RESUME_WMASK   8'h03
`define ULST_POLICY_RESET   8'h00
`define ULST_POLICY_WMASK   8'h07
`define ULST_B_ALIGN_EN     2
`define ULST_B_HALT_MODE    1
`define ULST_B_STATIC_BM    0
`define ULST_CFG1_RESET     8'h00
`define ULST_CFG1_WMASK     8'h01
`define ULST_B_ARB_DIS      0

// Gate pass-through command bytes
`define ULST_GATE_CMD       8'hd1
`define ULST_GATE_END       8'hff
`define ULST_B_GATE_DATA    1

// Pass-through states
`define ULST_PS_IDLE        2'h0
`define ULST_PS_DATA        2'h1
`define ULST_PS_END         2'h2

`endif

/* File: tb/ulst_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ulst_checker (
    input wire        i_clk,
    input wire        i_reset,
    input wire        i_cfg_wr,
    input wire        i_cfg_rd,
    input wire [7:0]  i_cfg_addr,
    input wire [3:0]  i_cfg_be,
    input wire [31:0] i_cfg_wdata,
    input wire [31:0] o_cfg_rdata,
    input wire        o_cfg_rvalid,
    input wire        i_kbc_access,
    input wire        i_kbc_write,
    input wire        i_kbc_cmd_port,
    input wire [4:0]  i_peer_enable,
    input wire [4:0]  o_status_clear,
    input wire        i_usb_irq,
    input wire        o_pci_irq,
    input wire        o_system_mgmt_interrupt,
    input wire [1:0]  i_port_wake_event,
    input wire        o_wake_event,
    input wire        i_run,
    input wire        i_heartbeat,
    input wire        i_halted_raw,
    input wire        i_mem_access_active,
    input wire        o_frame_start_enable,
    input wire        o_busmaster_status
);
    // Shadows of the enables, masked as reserved bits are
    logic       en13;
    logic       en4;
    logic [1:0] wen;
    logic [2:0] pol;
    wire        wl = i_cfg_wr && i_cfg_addr == 8'hc0;
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            {en13, en4, wen, pol} <= 7'h40;
        end else if (i_cfg_wr) begin
            if (wl && i_cfg_be[1]) en13 <= i_cfg_wdata[13];
            if (wl && i_cfg_be[0]) en4 <= i_cfg_wdata[4];
            if (i_cfg_addr == 8'hc4 && i_cfg_be[0]) wen <= i_cfg_wdata[1:0];
            if (i_cfg_addr == 8'hc8 && i_cfg_be[0]) pol <= i_cfg_wdata[2:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_cmd_read;
        i_kbc_access && !i_kbc_write && i_kbc_cmd_port && i_peer_enable[2];
    endsequence
    sequence s_run_start;
        $rose(i_run) && pol[2] && !i_heartbeat;
    endsequence
    sequence s_run_wait;
        s_run_start ##1 !i_heartbeat [*2];
    endsequence
    chk_pci_irq_gate: assert property (o_pci_irq == $past(i_usb_irq && en13))
        else $error("pci irq not gated");
    chk_unmapped_zero: assert property (i_cfg_rd && !(i_cfg_addr inside {8'hc0, 8'hc4, 8'hc8})
        |=> o_cfg_rvalid && o_cfg_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_wake_mask: assert property (o_wake_event == $past(|(i_port_wake_event & wen)))
        else $error("wake not masked");
    chk_clear_echo: assert property (wl && i_cfg_be[1]
        |=> o_status_clear == $past({i_cfg_wdata[15], i_cfg_wdata[11:8]}))
        else $error("clear not shared");
    chk_trap_smi: assert property (s_cmd_read |-> ##[1:3] o_system_mgmt_interrupt)
        else $error("trap smi missing");
    chk_usb_smi: assert property ((i_usb_irq && en4) [*3] |-> o_system_mgmt_interrupt)
        else $error("usb smi missing");
    chk_static_bm: assert property ((pol[0] && !i_halted_raw) [*3] |-> o_busmaster_status)
        else $error("static bm low");
    chk_dynamic_bm: assert property ((!pol[0] && !i_mem_access_active) [*3]
        |-> !o_busmaster_status)
        else $error("dynamic bm high");
    chk_align_wait: assert property (s_run_wait |-> !o_frame_start_enable)
        else $error("frame began before heartbeat");
    chk_align_first: assert property (s_run_start |=> !o_frame_start_enable)
        else $error("frame leaked on run edge");
endmodule // ulst_checker
`default_nettype wire

/* File: tb/ulst_kbc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ulst_kbc_host (
    input  wire        i_clk,
    output logic       o_access,
    output logic       o_write,
    output logic       o_cmd,
    output logic [7:0] o_data
);
    initial {o_access, o_write, o_cmd, o_data} = 11'h0;
    task cyc(input logic w, input logic c, input logic [7:0] d);
        @(posedge i_clk);
        #1 {o_access, o_write, o_cmd, o_data} = {1'b1, w, c, d};
        @(posedge i_clk);
        #1 o_access = 1'b0;
        // Released byte flips so a stale value never looks valid
        o_data = ~d;
    endtask
endmodule // ulst_kbc_host
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_cfg_wr = 1'b0;
    logic        i_cfg_rd = 1'b0;
    logic [7:0]  i_cfg_addr = 8'h0;
    logic [3:0]  i_cfg_be = 4'h0;
    logic [31:0] i_cfg_wdata = 32'h0;
    logic [4:0]  i_peer_enable = 5'h0;
    logic [4:0]  i_peer_status_clear = 5'h0;
    logic        i_usb_irq = 1'b0;
    logic        i_run = 1'b0;
    logic        i_heartbeat = 1'b0;
    logic        i_halted_raw = 1'b1;
    logic        i_mem_access_active = 1'b0;
    logic        i_dma_read_pending = 1'b0;
    logic [1:0]  i_port_wake_event = 2'h0;
    wire         i_kbc_access, i_kbc_write, i_kbc_cmd_port;
    wire  [7:0]  i_kbc_wdata;
    wire  [31:0] o_cfg_rdata;
    wire  [4:0]  o_local_enable, o_status_clear;
    wire         o_cfg_rvalid, o_address_line_gate, o_pci_irq, o_system_mgmt_interrupt;
    wire         o_wake_event, o_frame_start_enable, o_controller_halted;
    wire         o_busmaster_status, o_target_completion_hold;
    int          n_errors = 0;
    int          checks_done = 0;
    ulst_trap_config dut (.*);
    ulst_kbc_host host (.i_clk(i_clk), .o_access(i_kbc_access), .o_write(i_kbc_write),
        .o_cmd(i_kbc_cmd_port), .o_data(i_kbc_wdata));
    always #12.5 i_clk = ~i_clk;
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task cw(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge i_clk);
        #1 {i_cfg_wr, i_cfg_addr, i_cfg_be, i_cfg_wdata} = {1'b1, a, b, d};
        @(posedge i_clk);
        #1 i_cfg_wr = 1'b0;
    endtask
    task cr(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge i_clk);
        #1 {i_cfg_rd, i_cfg_addr} = {1'b1, a};
        @(posedge i_clk);
        #1 i_cfg_rd = 1'b0;
        cb("rvalid", 1'b1, o_cfg_rvalid);
        chk(nm, e, o_cfg_rdata);
    endtask
    task t_regs;
        cr(8'hc0, 32'h2000, "legacy");
        cr(8'hc4, 32'h0, "resume");
        cr(8'hc8, 32'h0, "policy");
        cw(8'hc4, 4'hf, 32'hffffffff);
        cw(8'hc8, 4'hf, 32'hffffffff);
        cw(8'hcc, 4'hf, 32'hffffffff);
        cr(8'hc4, 32'h3, "resume");
        cr(8'hc8, 32'h00010007, "policy");
        cr(8'hcc, 32'h0, "unmapped");
        cw(8'hc8, 4'hf, 32'h0);
        $display("t_regs done");
    endtask
    task t_traps;
        for (int i = 0; i < 4; i++) begin
            host.cyc(i[0], i[1], 8'h5a);
            cr(8'hc0, 32'h2000 | (32'h100 << i), "trap");
            cb("smi", 1'b0, o_system_mgmt_interrupt);
            cw(8'hc0, 4'h2, 32'h2000 | (32'h100 << i));
            cr(8'hc0, 32'h2000, "clear");
            i_peer_enable = 5'(1 << i);
            host.cyc(i[0], i[1], 8'h5a);
            tick(2);
            cb("smi", 1'b1, o_system_mgmt_interrupt);
            cw(8'hc0, 4'h2, 32'h2000 | (32'h100 << i));
            i_peer_enable = 5'h0;
        end
        $display("t_traps done");
    endtask
    task t_gate;
        cw(8'hc0, 4'h1, 32'ha0);
        host.cyc(1'b1, 1'b1, 8'hd1);
        cr(8'hc0, 32'h20e0, "mid");
        host.cyc(1'b1, 1'b0, 8'h02);
        cr(8'hc0, 32'h20e0, "mid");
        cb("gate", 1'b1, o_address_line_gate);
        host.cyc(1'b1, 1'b1, 8'hff);
        cr(8'hc0, 32'ha0a0, "end");
        cb("end smi", 1'b1, o_system_mgmt_interrupt);
        cw(8'hc0, 4'h2, 32'ha000);
        host.cyc(1'b1, 1'b1, 8'hd1);
        host.cyc(1'b0, 1'b0, 8'h00);
        cr(8'hc0, 32'h21a0, "abort");
        host.cyc(1'b1, 1'b1, 8'hd1);
        cw(8'hc0, 4'h1, 32'h0);
        cr(8'hc0, 32'h2100, "pass off");
        cw(8'hc0, 4'h2, 32'h2100);
        $display("t_gate done");
    endtask
    task t_irq;
        i_usb_irq = 1'b1;
        cw(8'hc0, 4'h2, 32'h3000);
        cr(8'hc0, 32'h3000, "usb sts");
        cb("pci irq", 1'b1, o_pci_irq);
        cw(8'hc0, 4'h3, 32'h0010);
        cr(8'hc0, 32'h1010, "irq off");
        cb("pci irq", 1'b0, o_pci_irq);
        cb("usb smi", 1'b1, o_system_mgmt_interrupt);
        i_usb_irq = 1'b0;
        cw(8'hc0, 4'h3, 32'h2000);
        cr(8'hc0, 32'h2000, "usb clr");
        $display("t_irq done");
    endtask
    task t_misc;
        cw(8'hc4, 4'h1, 32'h1);
        i_port_wake_event = 2'b10;
        tick(2);
        cb("wake", 1'b0, o_wake_event);
        i_port_wake_event = 2'b01;
        tick(2);
        cb("wake", 1'b1, o_wake_event);
        i_mem_access_active = 1'b1;
        tick(3);
        cb("bm", 1'b1, o_busmaster_status);
        i_mem_access_active = 1'b0;
        cw(8'hc8, 4'h5, 32'h10001);
        i_halted_raw = 1'b0;
        i_dma_read_pending = 1'b1;
        tick(3);
        cb("bm", 1'b1, o_busmaster_status);
        cb("hold", 1'b1, o_target_completion_hold);
        cw(8'hc8, 4'h5, 32'h4);
        i_run = 1'b1;
        tick(2);
        cb("frame", 1'b0, o_frame_start_enable);
        cb("halted", 1'b1, o_controller_halted);
        cb("hold", 1'b0, o_target_completion_hold);
        i_heartbeat = 1'b1;
        tick(1);
        i_heartbeat = 1'b0;
        tick(2);
        cb("frame", 1'b1, o_frame_start_enable);
        i_run = 1'b0;
        i_halted_raw = 1'b1;
        cw(8'hc8, 4'h1, 32'h6);
        i_run = 1'b1;
        tick(2);
        cb("halted", 1'b0, o_controller_halted);
        cb("frame", 1'b0, o_frame_start_enable);
        $display("t_misc done");
    endtask
    task t_share;
        cw(8'hc0, 4'h3, 32'h208f);
        tick(1);
        chk("local en", 32'h1f, {27'h0, o_local_enable});
        host.cyc(1'b0, 1'b1, 8'h00);
        tick(1);
        i_peer_status_clear = 5'h04;
        tick(1);
        i_peer_status_clear = 5'h00;
        cr(8'hc0, 32'h208f, "peer clr");
        cw(8'hc0, 4'h3, 32'h2000);
        $display("t_share done");
    endtask
    task summarize;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        #1 i_reset = 1'b0;
        t_regs;
        t_traps;
        t_gate;
        t_irq;
        t_share;
        t_misc;
        summarize;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #25000;
        n_errors++;
        summarize;
    end
endmodule // tb
bind ulst_trap_config ulst_checker u_chk (.*);
`default_nettype wire
